// ### hw/rls_pkg.sv
// constants, types and shared decoding for the radio link settings bank
package rls_pkg;

  // ----------------------------------------------------------------------
  // frame bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0] FRM_START     = 8'h02;
  localparam logic [7:0] CMD_WRITE     = 8'h09;
  localparam logic [7:0] CMD_READ      = 8'h0A;
  localparam logic [7:0] CNF_WRITE     = 8'h49;
  localparam logic [7:0] CNF_READ      = 8'h4A;
  localparam logic [7:0] STAT_OK       = 8'h00;
  localparam logic [7:0] STAT_FAIL     = 8'h01;
  localparam logic [7:0] READ_REQ_LEN  = 8'h02;
  localparam logic [7:0] SHORT_CNF_LEN = 8'h01;
  localparam logic [7:0] WRITE_MIN_LEN = 8'h02;
  localparam logic [7:0] BCAST_ID      = 8'hFF;

  // response frame positions
  localparam logic [7:0] POS_CMD       = 8'h01;
  localparam logic [7:0] POS_LEN       = 8'h02;
  localparam logic [7:0] POS_STAT      = 8'h03;
  localparam logic [7:0] POS_DATA      = 8'h04;

  // ----------------------------------------------------------------------
  // settings map
  // ----------------------------------------------------------------------
  localparam int         OFS_FIRST     = 1;
  localparam int         OFS_LAST      = 4;
  localparam logic [7:0] OFS_AIR_RATE  = 8'h01;
  localparam logic [7:0] OFS_GROUP     = 8'h02;
  localparam logic [7:0] OFS_NODE      = 8'h03;
  localparam logic [7:0] OFS_STRENGTH  = 8'h04;
  localparam int         BODY_BYTES    = 5;
  localparam logic [7:0] WRITE_MAX_LEN = 8'h05;

  // values after a cold start, indexed by offset
  localparam logic [7:0] RST_TABLE [OFS_FIRST:OFS_LAST] =
    '{8'h01, 8'hA9, 8'h00, 8'h0A};

  // air data rate in units of 100 bit/s, indexed by rate code
  localparam logic [9:0] RATE_TABLE [1:7] =
    '{10'h00F, 10'h01E, 10'h03C, 10'h078, 10'h0F0, 10'h1E0, 10'h2D0};
  localparam logic [7:0] RATE_CODE_MIN = 8'h01;
  localparam logic [7:0] RATE_CODE_MAX = 8'h07;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] air_rate;
    logic [7:0] group;
    logic [7:0] node;
    logic [7:0] strength;
  } rls_settings_type;

  typedef struct packed {
    logic [7:0] lane;
    logic [7:0] group;
    logic [7:0] dest;
  } rls_pkt_hdr_type;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_CMD    = 4'b0001,
    ST_LEN    = 4'b0010,
    ST_BODY   = 4'b0011,
    ST_CHECK  = 4'b0100,
    ST_COMMIT = 4'b0101,
    ST_SEND   = 4'b0110,
    ST_FETCH  = 4'b0111
  } rls_state_type;

  // a span of settings lies wholly inside the map
  function automatic logic range_ok(input logic [7:0] ofs,
                                    input logic [7:0] cnt);
    logic [8:0] span_end;
    span_end = {1'b0, ofs} + {1'b0, cnt};
    return (cnt != 8'h00) && (ofs >= 8'(OFS_FIRST)) &&
           (ofs <= 8'(OFS_LAST)) && (span_end <= 9'(OFS_LAST + 1));
  endfunction

endpackage

// ### hw/rls_store.sv
// stored settings cells with a write port and a registered read port
module rls_store
  import rls_pkg::*;
(
  // clock and cold start
  input  wire logic             sys_clk,
  input  wire logic             por,
  // write port
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_ofs,
  input  wire logic [7:0]       wr_data,
  // read port
  input  wire logic [7:0]       rd_ofs,
  output logic      [7:0]       rd_data_reg,
  // whole content
  output rls_settings_type      stored
);

  logic [7:0] mem_reg [OFS_FIRST:OFS_LAST];

  // ----------------------------------------------------------------------
  // cells, kept across warm resets
  // ----------------------------------------------------------------------
  for (genvar i = OFS_FIRST; i <= OFS_LAST; i++) begin : g_cell
    always_ff @(posedge sys_clk) begin
      if (por) begin
        mem_reg[i] <= RST_TABLE[i];
      end else if (wr_en && wr_ofs == 8'(i)) begin
        mem_reg[i] <= wr_data;
      end
    end
  end

  // registered read, unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (por) begin
      rd_data_reg <= 8'h00;
    end else if (range_ok(rd_ofs, 8'h01)) begin
      rd_data_reg <= mem_reg[rd_ofs[2:0]];
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  // whole content for loading after reset
  assign stored.air_rate = mem_reg[OFS_AIR_RATE[2:0]];
  assign stored.group    = mem_reg[OFS_GROUP[2:0]];
  assign stored.node     = mem_reg[OFS_NODE[2:0]];
  assign stored.strength = mem_reg[OFS_STRENGTH[2:0]];

  a_por_default: assert property (@(posedge sys_clk)
    por |=> stored.group == 8'hA9 && stored.air_rate == 8'h01)
    else $error("cold start did not restore defaults");

endmodule

// ### hw/rls_filter.sv
// packet address filter and sender stamp using the active settings
module rls_filter
  import rls_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // active settings and lane
  input  rls_settings_type      act,
  input  wire logic [7:0]       own_lane,
  // incoming packet header
  input  rls_pkt_hdr_type       hdr,
  input  wire logic             hdr_valid,
  // verdict and sender stamp
  output logic                  accept_reg,
  output logic                  reject_reg,
  output logic      [7:0]       src_id_reg
);

  logic peer_ok;
  logic addr_ok;

  // same group and lane, then own or broadcast destination
  always_comb begin
    peer_ok = (hdr.group == act.group) && (hdr.lane == own_lane);
    addr_ok = (hdr.dest == act.node) ||
              (hdr.dest == BCAST_ID);
  end

  // one-cycle verdict per header
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accept_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      accept_reg <= hdr_valid && peer_ok && addr_ok;
      reject_reg <= hdr_valid && !(peer_ok && addr_ok);
    end
  end

  // sender field of every outgoing packet
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_id_reg <= 8'h00;
    end else begin
      src_id_reg <= act.node;
    end
  end

  a_bcast_accept: assert property (@(posedge sys_clk) disable iff (rst)
    hdr_valid && peer_ok && hdr.dest == 8'hFF |=> accept_reg)
    else $error("broadcast packet not accepted");

  a_foreign_drop: assert property (@(posedge sys_clk) disable iff (rst)
    hdr_valid && hdr.group != act.group |=> reject_reg && !accept_reg)
    else $error("packet of another group accepted");

  a_src_stamp: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> src_id_reg == $past(act.node))
    else $error("sender field differs from own node id");

endmodule

// ### hw/rls_bank.sv
// settings bank: command frame engine, active settings and packet filter
module rls_bank
  import rls_pkg::*;
(
  // clock and resets
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             por,
  // command bytes from host
  input  wire logic [7:0]       rx_data,
  input  wire logic             rx_valid,
  output logic                  rx_ready_reg,
  // confirmation bytes to host
  output logic      [7:0]       tx_data_reg,
  output logic                  tx_valid_reg,
  input  wire logic             tx_ready,
  output logic                  cs_error_reg,
  // radio side
  input  wire logic [7:0]       own_lane,
  input  rls_pkt_hdr_type       pkt_hdr,
  input  wire logic             pkt_hdr_valid,
  output logic                  pkt_accept_reg,
  output logic                  pkt_reject_reg,
  output logic      [7:0]       pkt_src_id_reg,
  // active link parameters
  output logic      [7:0]       air_rate_code_reg,
  output logic      [9:0]       air_rate_x100_reg,
  output logic signed [7:0]     tx_strength_reg
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  rls_state_type    state_reg;
  rls_state_type    state_next;
  rls_settings_type act_reg;
  rls_settings_type stored;
  logic [7:0]       body_reg [0:BODY_BYTES-1];
  logic [7:0]       cmd_reg;
  logic [7:0]       len_reg;
  logic [7:0]       pos_reg;
  logic [7:0]       rx_cs_reg;
  logic [7:0]       wr_idx_reg;
  logic [7:0]       tx_pos_reg;
  logic [7:0]       tx_cs_reg;
  logic [7:0]       resp_cmd_reg;
  logic [7:0]       resp_len_reg;
  logic [7:0]       resp_stat_reg;
  logic             load_pend_reg;
  logic             rx_take;
  logic             cs_match;
  logic             wr_ok;
  logic             rd_ok;
  logic             cmd_known;
  logic             tx_load;
  logic [7:0]       tx_byte;
  logic [7:0]       tx_last;
  logic [7:0]       rd_ofs;
  logic [7:0]       rd_data;
  logic             wr_en;
  logic [7:0]       wr_ofs;
  logic [7:0]       wr_data;

  // ----------------------------------------------------------------------
  // request decoding
  // ----------------------------------------------------------------------
  always_comb begin
    rx_take   = rx_valid && rx_ready_reg;
    cs_match  = (rx_data == rx_cs_reg);
    cmd_known = (cmd_reg == CMD_WRITE) || (cmd_reg == CMD_READ);
    wr_ok     = (cmd_reg == CMD_WRITE) && (len_reg >= WRITE_MIN_LEN) &&
                (len_reg <= WRITE_MAX_LEN) &&
                range_ok(body_reg[0], len_reg - 8'h01);
    rd_ok     = (cmd_reg == CMD_READ) && (len_reg == READ_REQ_LEN) &&
                range_ok(body_reg[0], body_reg[1]);
  end

  // next state of the frame engine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rx_take && rx_data == FRM_START) begin
          state_next = ST_CMD;
        end
      end
      ST_CMD: begin
        if (rx_take) begin
          state_next = ST_LEN;
        end
      end
      ST_LEN: begin
        if (rx_take) begin
          state_next = (rx_data == 8'h00) ? ST_CHECK : ST_BODY;
        end
      end
      ST_BODY: begin
        if (rx_take && pos_reg + 8'h01 == len_reg) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (rx_take) begin
          if (!cs_match || !cmd_known) begin
            state_next = ST_IDLE;
          end else begin
            state_next = wr_ok ? ST_COMMIT : ST_SEND;
          end
        end
      end
      ST_COMMIT: begin
        if (wr_idx_reg + 8'h02 >= len_reg) begin
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_load) begin
          if (tx_pos_reg == tx_last) begin
            state_next = ST_IDLE;
          end else if (tx_pos_reg >= POS_STAT) begin
            state_next = ST_FETCH;
          end
        end
      end
      ST_FETCH: state_next = ST_SEND;
      default:  state_next = ST_IDLE;
    endcase
  end

  // state and host-side ready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      rx_ready_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      rx_ready_reg <= (state_next != ST_COMMIT) &&
                      (state_next != ST_SEND) &&
                      (state_next != ST_FETCH) && !load_pend_reg;
    end
  end

  // ----------------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_reg   <= 8'h00;
      len_reg   <= 8'h00;
      pos_reg   <= 8'h00;
      rx_cs_reg <= 8'h00;
    end else if (rx_take) begin
      rx_cs_reg <= (state_reg == ST_IDLE) ? rx_data :
                   rx_cs_reg ^ rx_data;
      if (state_reg == ST_CMD) begin
        cmd_reg <= rx_data;
      end
      if (state_reg == ST_LEN) begin
        len_reg <= rx_data;
        pos_reg <= 8'h00;
      end
      if (state_reg == ST_BODY) begin
        pos_reg <= pos_reg + 8'h01;
      end
    end
  end

  // body bytes beyond the buffer are consumed but not kept
  for (genvar i = 0; i < BODY_BYTES; i++) begin : g_body
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        body_reg[i] <= 8'h00;
      end else if (rx_take && state_reg == ST_BODY && pos_reg == 8'(i)) begin
        body_reg[i] <= rx_data;
      end
    end
  end

  // checksum failure drops the frame unconfirmed and pulses cs_error_reg
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_error_reg <= 1'b0;
    end else begin
      cs_error_reg <= rx_take && state_reg == ST_CHECK && !cs_match;
    end
  end

  // confirmation header chosen when the check byte is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_cmd_reg  <= 8'h00;
      resp_len_reg  <= 8'h00;
      resp_stat_reg <= 8'h00;
    end else if (rx_take && state_reg == ST_CHECK) begin
      if (cmd_reg == CMD_WRITE) begin
        resp_cmd_reg  <= CNF_WRITE;
        resp_len_reg  <= SHORT_CNF_LEN;
        resp_stat_reg <= wr_ok ? STAT_OK : STAT_FAIL;
      end else if (rd_ok) begin
        resp_cmd_reg  <= CNF_READ;
        resp_len_reg  <= body_reg[1] + 8'h01;
        resp_stat_reg <= body_reg[0];
      end else begin
        resp_cmd_reg  <= CNF_READ;
        resp_len_reg  <= SHORT_CNF_LEN;
        resp_stat_reg <= STAT_FAIL;
      end
    end
  end

  // ----------------------------------------------------------------------
  // store access
  // ----------------------------------------------------------------------
  always_comb begin
    wr_en   = (state_reg == ST_COMMIT);
    wr_ofs  = body_reg[0] + wr_idx_reg;
    wr_data = body_reg[3'(wr_idx_reg) + 3'h1];
    rd_ofs  = body_reg[0] + tx_pos_reg - POS_DATA;
  end

  // one parameter byte written per cycle
  always_ff @(posedge sys_clk) begin
    if (rst || state_reg != ST_COMMIT) begin
      wr_idx_reg <= 8'h00;
    end else begin
      wr_idx_reg <= wr_idx_reg + 8'h01;
    end
  end

  rls_store u_store (
    .sys_clk     (sys_clk),
    .por         (por),
    .wr_en       (wr_en),
    .wr_ofs      (wr_ofs),
    .wr_data     (wr_data),
    .rd_ofs      (rd_ofs),
    .rd_data_reg (rd_data),
    .stored      (stored)
  );

  // ----------------------------------------------------------------------
  // confirmation sender
  // ----------------------------------------------------------------------
  always_comb begin
    tx_load = (state_reg == ST_SEND) && (!tx_valid_reg || tx_ready);
    tx_last = resp_len_reg + POS_STAT;
    case (tx_pos_reg)
      8'h00:    tx_byte = FRM_START;
      POS_CMD:  tx_byte = resp_cmd_reg;
      POS_LEN:  tx_byte = resp_len_reg;
      POS_STAT: tx_byte = resp_stat_reg;
      default:  tx_byte = (tx_pos_reg == tx_last) ? tx_cs_reg : rd_data;
    endcase
  end

  // output byte holds until the host takes it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data_reg  <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_pos_reg   <= 8'h00;
      tx_cs_reg    <= 8'h00;
    end else if (tx_load) begin
      tx_data_reg  <= tx_byte;
      tx_valid_reg <= 1'b1;
      tx_pos_reg   <= (tx_pos_reg == tx_last) ? 8'h00 : tx_pos_reg + 8'h01;
      tx_cs_reg    <= (tx_pos_reg == 8'h00) ? tx_byte :
                      tx_cs_reg ^ tx_byte;
    end else if (tx_ready) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // active settings, taken from the store once after each reset
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      load_pend_reg <= 1'b1;
      act_reg       <= '{RST_TABLE[1], RST_TABLE[2], RST_TABLE[3],
                         RST_TABLE[4]};
    end else if (load_pend_reg) begin
      load_pend_reg <= 1'b0;
      act_reg       <= stored;
    end
  end

  // link parameter outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      air_rate_code_reg <= 8'h00;
      air_rate_x100_reg <= 10'h000;
      tx_strength_reg   <= 8'sh00;
    end else begin
      air_rate_code_reg <= act_reg.air_rate;
      tx_strength_reg   <= signed'(act_reg.strength);
      if (act_reg.air_rate >= RATE_CODE_MIN &&
          act_reg.air_rate <= RATE_CODE_MAX) begin
        air_rate_x100_reg <= RATE_TABLE[act_reg.air_rate[2:0]];
      end else begin
        air_rate_x100_reg <= 10'h000;
      end
    end
  end

  rls_filter u_filter (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .act        (act_reg),
    .own_lane   (own_lane),
    .hdr        (pkt_hdr),
    .hdr_valid  (pkt_hdr_valid),
    .accept_reg (pkt_accept_reg),
    .reject_reg (pkt_reject_reg),
    .src_id_reg (pkt_src_id_reg)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_good_write;
    rx_take && state_reg == ST_CHECK && cs_match && wr_ok;
  endsequence
  sequence s_send_start;
    tx_load && tx_pos_reg == 8'h00;
  endsequence

  a_write_confirm: assert property (
    s_good_write |-> ##[2:6] s_send_start)
    else $error("write request not confirmed in time");
  a_busy_no_rx: assert property (
    state_reg inside {ST_COMMIT, ST_SEND, ST_FETCH} |-> !rx_ready_reg)
    else $error("host bytes taken while busy");
  a_tx_hold: assert property (
    tx_valid_reg && !tx_ready |=> tx_valid_reg && $stable(tx_data_reg))
    else $error("confirmation byte changed before taken");
  a_write_fail: assert property (
    rx_take && state_reg == ST_CHECK && cs_match &&
    cmd_reg == CMD_WRITE && !wr_ok
    |=> state_reg == ST_SEND && resp_stat_reg == 8'h01)
    else $error("failed write not reported with status 0x01");
  a_read_len: assert property (
    rx_take && state_reg == ST_CHECK && cs_match && rd_ok
    |=> resp_len_reg == $past(body_reg[1]) + 8'h01)
    else $error("read reply length not count plus one");
  a_read_fail: assert property (
    rx_take && state_reg == ST_CHECK && cs_match &&
    cmd_reg == CMD_READ && !rd_ok
    |=> resp_len_reg == 8'h01 && resp_stat_reg == 8'h01)
    else $error("failed read reply malformed");
  a_bad_cs_drop: assert property (
    rx_take && state_reg == ST_CHECK && !cs_match
    |=> cs_error_reg && state_reg == ST_IDLE)
    else $error("frame with bad check byte not dropped");
  a_active_hold: assert property (
    !load_pend_reg |=> $stable(act_reg))
    else $error("active settings changed without reset");
  a_rate_map: assert property (
    act_reg.air_rate == 8'h07 |=> air_rate_x100_reg == 10'h2D0)
    else $error("rate code 7 not mapped to 72 kbps");

endmodule

// ### dv/rls_host.sv
// host controller model: sends command frames and collects confirmations
module rls_host (
  // clock
  input  wire logic       sys_clk,
  // command link
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready_reg,
  // confirmation link
  input  wire logic [7:0] tx_data_reg,
  input  wire logic       tx_valid_reg,
  output logic            tx_ready,
  // pacing: take confirmation bytes every other cycle
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle link at time zero
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // one byte held until taken, then the line shows the inverse
  task automatic put(input logic [7:0] b);
    logic rdy;
    int   k;
    @(negedge sys_clk);
    rx_data  = b;
    rx_valid = 1'b1;
    for (k = 0; k < 200; k++) begin
      rdy = rx_ready_reg;
      @(negedge sys_clk);
      if (rdy) break;
    end
    rx_valid = 1'b0;
    rx_data  = ~b;
  endtask

  // frame plus check byte, then m confirmation bytes
  task automatic xfer(input logic [7:0] f[$], input logic bad,
                      input int m, output logic [7:0] r[$]);
    logic [7:0] cs;
    int         k;
    cs = 8'h00;
    r  = {};
    foreach (f[j]) begin
      put(f[j]);
      cs ^= f[j];
    end
    put(cs ^ {7'h00, bad});
    k = 0;
    while (r.size() < m && k < 400) begin
      @(negedge sys_clk);
      tx_ready = slow ? ~tx_ready : 1'b1;
      if (tx_valid_reg && tx_ready) r.push_back(tx_data_reg);
      k++;
    end
    @(negedge sys_clk);
    tx_ready = 1'b0;
  endtask
endmodule

// ### dv/tb.sv
// self-checking bench for the settings bank
module tb
  import rls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [63:0] q;
    int          n;
    logic [63:0] a;
    int          m;
  } rls_row_type;

  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              por = 1'b1;
  logic              slow = 1'b0;
  logic              pkt_hdr_valid = 1'b0;
  logic        [7:0] own_lane = 8'h03;
  rls_pkt_hdr_type   pkt_hdr = '0;
  logic              rx_valid, rx_ready_reg, tx_valid_reg, tx_ready;
  logic              cs_error_reg, pkt_accept_reg, pkt_reject_reg;
  logic        [7:0] rx_data, tx_data_reg, pkt_src_id_reg;
  logic        [7:0] air_rate_code_reg;
  logic        [9:0] air_rate_x100_reg;
  logic signed [7:0] tx_strength_reg;
  logic        [7:0] r[$];
  int                n_fail = 0;
  int                num_checks = 0;
  int                n_cserr = 0;
  int                i;

  // request bytes, count, reply bytes without check byte, count
  rls_row_type rows [10] = '{
    '{64'h02_0A02_0101, 5, 64'h02_4A02_0101, 5},
    '{64'h02_0A02_0201, 5, 64'h02_4A02_02A9, 5},
    '{64'h02_0A02_0301, 5, 64'h02_4A02_0300, 5},
    '{64'h02_0A02_0401, 5, 64'h02_4A02_040A, 5},
    '{64'h02_0A02_0104, 5, 64'h024A_0501_01A9_000A, 8},
    '{64'h0209_0501_0712_05FF, 8, 64'h0249_0100, 4},
    '{64'h02_0A02_0104, 5, 64'h024A_0501_0712_05FF, 8},
    '{64'h02_0902_0006, 5, 64'h0249_0101, 4},
    '{64'h02_0A02_0100, 5, 64'h024A_0101, 4},
    '{64'h02_0A02_0402, 5, 64'h024A_0101, 4}};
  rls_pkt_hdr_type hdrs [5] = '{24'h03_1205, 24'h03_12FF, 24'h03_1206,
                                24'h03_1305, 24'h04_12FF};
  logic [9:0] rates [7] = '{10'h00F, 10'h01E, 10'h03C, 10'h078, 10'h0F0,
                            10'h1E0, 10'h2D0};

  rls_bank dut (.sys_clk, .rst, .por, .rx_data, .rx_valid, .rx_ready_reg,
    .tx_data_reg, .tx_valid_reg, .tx_ready, .cs_error_reg, .own_lane,
    .pkt_hdr, .pkt_hdr_valid, .pkt_accept_reg, .pkt_reject_reg,
    .pkt_src_id_reg, .air_rate_code_reg, .air_rate_x100_reg,
    .tx_strength_reg);
  rls_host host (.sys_clk, .rx_data, .rx_valid, .rx_ready_reg,
    .tx_data_reg, .tx_valid_reg, .tx_ready, .slow);

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // count check byte error pulses
  always @(posedge sys_clk) begin
    if (cs_error_reg === 1'b1) n_cserr <= n_cserr + 1;
  end

  task automatic chk(input logic [63:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // reset for 8 cycles, cold start too when asked
  task automatic do_rst(input logic cold);
    @(negedge sys_clk);
    rst = 1'b1;
    por = cold;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    por = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic chk_act(input logic [7:0] rate, input logic [9:0] x100,
                         input logic [7:0] str, node);
    chk(air_rate_code_reg, rate, "rate code");
    chk(air_rate_x100_reg, x100, "rate value");
    chk({tx_strength_reg}, str, "strength");
    chk(pkt_src_id_reg, node, "sender id");
  endtask

  // one frame exchange checked byte by byte
  task automatic run(input rls_row_type w);
    logic [7:0] f[$], q8[$], cs;
    int         k;
    f  = {};
    cs = 8'h00;
    for (k = w.n - 1; k >= 0; k--) f.push_back(w.q[8*k +: 8]);
    host.xfer(f, 1'b0, w.m + 1, q8);
    chk(q8.size(), w.m + 1, "reply size");
    for (k = 0; k < w.m; k++) begin
      chk(q8[k], w.a[8*(w.m-1-k) +: 8], "reply byte");
      cs ^= w.a[8*(w.m-1-k) +: 8];
    end
    chk(q8[w.m], cs, "reply check byte");
  endtask

  // main sequence
  initial begin
    do_rst(1'b1);
    chk_act(8'h01, 10'h00F, 8'h0A, 8'h00);
    for (i = 0; i < 10; i++) begin
      slow = i[0];
      run(rows[i]);
    end
    chk_act(8'h01, 10'h00F, 8'h0A, 8'h00);
    for (i = 1; i <= 7; i++) begin
      run('{64'h02_0902_0100 | 64'(i), 5, 64'h0249_0100, 4});
      do_rst(1'b0);
      chk_act(8'(i), rates[i-1], 8'hFF, 8'h05);
    end
    for (i = 0; i < 5; i++) begin
      pkt_hdr = hdrs[i];
      pkt_hdr_valid = 1'b1;
      @(negedge sys_clk);
      chk({pkt_accept_reg, pkt_reject_reg}, {i < 2, i >= 2}, "filter");
    end
    pkt_hdr_valid = 1'b0;
    host.put(8'h55);
    host.xfer('{8'h02, 8'h11, 8'h00}, 1'b0, 0, r);
    host.xfer('{8'h02, 8'h0A, 8'h02, 8'h03, 8'h01}, 1'b1, 0, r);
    run('{64'h02_0A02_0301, 5, 64'h02_4A02_0305, 5});
    chk(n_cserr, 1, "check byte error");
    close_out();
  end

  // watchdog
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
